/* File: cfgr_cfg.svh */
// Offsets, field positions, reset values and timing counts of the config register core
// How it works
// - Read-to-clear fields return their value, then clear as a side effect of the read.
// - Self-clearing bits accept a one, perform the action, then return to zero alone.
// - Strap-loaded fields start from the sampled strap pins; writable ones may be rewritten.
// - Latched-low and latched-high status fields hold the captured condition until read.
// - Address register bits 7-1 hold the 7-bit bus address, defaulting to the strap.
// - Bit 0 picks the address source: 0 strap, 1 programmed; resets to 0.
// - Writing 1 to reset bit 1 resets all logic and registers, then self-clears.
// - That full reset reloads strap-loaded registers with their original strap values.
// - Writing 1 to reset bit 0 resets logic but keeps registers, then self-clears.
// - The device acknowledges each received write byte by pulling the data line low.
// - On an address mismatch the device does not acknowledge and releases the data line.
`ifndef CFGR_CFG_SVH
`define CFGR_CFG_SVH
`define CFGR_OFF_BUS_ADDR   8'h00
`define CFGR_OFF_SOFT_RST   8'h01
`define CFGR_OFF_LATCH      8'h2c
`define CFGR_BIT_SRC_SEL    0
`define CFGR_BIT_KEEP_REGS  0
`define CFGR_BIT_FULL       1
`define CFGR_BUS_ADDR_RST   8'h00
`define CFGR_LL_RST         4'hf
`define CFGR_LH_RST         4'h0
`define CFGR_CLK_MHZ        10
`define CFGR_RST_PULSE_NS   1000
`define CFGR_RST_CYCLES     ((`CFGR_RST_PULSE_NS * `CFGR_CLK_MHZ + 999) / 1000)
`define CFGR_STRAP_SETTLE   2'h2
`define CFGR_STRAP_ADDR0    7'h2c
`define CFGR_STRAP_ADDR1    7'h2e
`define CFGR_STRAP_ADDR2    7'h30
`define CFGR_STRAP_ADDR3    7'h32
`define CFGR_STRAP_ADDR4    7'h34
`define CFGR_STRAP_ADDR5    7'h36
`define CFGR_STRAP_ADDR6    7'h38
`define CFGR_STRAP_ADDR7    7'h3c
`endif

/* File: cfgr_pkg.sv */
// Types shared by the config register core modules
`default_nettype none
package cfgr_pkg;
  typedef logic [7:0] cfgr_byte_t;
  typedef enum logic [3:0] {
    CFGR_ST_IDLE     = 4'b0000,
    CFGR_ST_ADDR     = 4'b0001,
    CFGR_ST_ADDR_ACK = 4'b0010,
    CFGR_ST_PTR      = 4'b0011,
    CFGR_ST_PTR_ACK  = 4'b0100,
    CFGR_ST_WDATA    = 4'b0101,
    CFGR_ST_WAIT_W   = 4'b0110,
    CFGR_ST_DATA_ACK = 4'b0111,
    CFGR_ST_WAIT_R   = 4'b1000,
    CFGR_ST_TX       = 4'b1001,
    CFGR_ST_MACK     = 4'b1010,
    CFGR_ST_MACK_OK  = 4'b1011
  } cfgr_i2c_e;
endpackage
`default_nettype wire

/* File: cfgr_link_if.sv */
// Crossing bundle between the serial slave and the register bank
`timescale 1ns/1ns
`default_nettype none
interface cfgr_link_if;
  import cfgr_pkg::*;
  logic       reqTgl;
  logic       reqWrite;
  cfgr_byte_t reqAddr;
  cfgr_byte_t reqData;
  logic       ackTgl;
  cfgr_byte_t rspData;
  logic       addrTgl;
  logic [6:0] busAddr;
  modport sys  (input reqTgl, reqWrite, reqAddr, reqData,
                output ackTgl, rspData, addrTgl, busAddr);
  modport link (output reqTgl, reqWrite, reqAddr, reqData,
                input ackTgl, rspData, addrTgl, busAddr);
endinterface
`default_nettype wire

/* File: cfgr_i2c_slave.sv */
// Serial control bus slave on the link clock
`timescale 1ns/1ns
`default_nettype none
module cfgr_i2c_slave
  import cfgr_pkg::*;
(
  input  wire logic clkLink,
  input  wire logic rst,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output var  logic sclOut,
  output var  logic sclOe,
  output var  logic sdaOut,
  output var  logic sdaOe,
  cfgr_link_if.link lnk
);
  logic       sclS1, sclS2, sclD, sdaS1, sdaS2, sdaD;
  logic       ackS1, ackS2, addrS1, addrS2, addrSeen;
  logic [6:0] myAddr;
  cfgr_i2c_e  state, next_state;
  cfgr_byte_t shiftReg, next_shiftReg, ptr, next_ptr;
  logic [3:0] bitCnt, next_bitCnt;
  logic       isRead, next_isRead, next_sdaOe, next_sclOe;
  logic       next_reqTgl, next_reqWrite;
  cfgr_byte_t next_reqAddr, next_reqData;
  logic       sclRise, sclFall, startCond, stopCond, busy;

  // Pin and handshake synchronisers
  always_ff @(posedge clkLink or posedge rst)
  begin
    if (rst)
    begin
      {sclS1, sclS2, sclD, sdaS1, sdaS2, sdaD} <= 6'h3f;
      {ackS1, ackS2, addrS1, addrS2, addrSeen} <= 5'h00;
      myAddr <= 7'h00;
    end
    else
    begin
      {sclS1, sclS2, sclD} <= {sclIn, sclS1, sclS2};
      {sdaS1, sdaS2, sdaD} <= {sdaIn, sdaS1, sdaS2};
      {ackS1, ackS2} <= {lnk.ackTgl, ackS1};
      {addrS1, addrS2, addrSeen} <= {lnk.addrTgl, addrS1, addrS2};
      if (addrS2 != addrSeen)
        myAddr <= lnk.busAddr;
    end
  end

  assign sclRise   = sclS2 && !sclD;
  assign sclFall   = !sclS2 && sclD;
  assign startCond = sclS2 && sclD && sdaD && !sdaS2;
  assign stopCond  = sclS2 && sclD && !sdaD && sdaS2;
  assign busy      = lnk.reqTgl != ackS2;

  always_comb
  begin
    next_state    = state;
    next_shiftReg = shiftReg;
    next_bitCnt   = bitCnt;
    next_ptr      = ptr;
    next_isRead   = isRead;
    next_sdaOe    = sdaOe;
    next_reqTgl   = lnk.reqTgl;
    next_reqWrite = lnk.reqWrite;
    next_reqAddr  = lnk.reqAddr;
    next_reqData  = lnk.reqData;
    case (state)
      CFGR_ST_ADDR, CFGR_ST_PTR, CFGR_ST_WDATA:
        if (sclRise)
        begin
          next_shiftReg = {shiftReg[6:0], sdaS2};
          next_bitCnt   = bitCnt + 4'h1;
        end
        else if (sclFall && bitCnt == 4'h8)
        begin
          next_bitCnt = 4'h0;
          if (state == CFGR_ST_ADDR)
          begin
            if (shiftReg[7:1] == myAddr)
            begin
              next_sdaOe  = 1'b1;
              next_isRead = shiftReg[0];
              next_state  = CFGR_ST_ADDR_ACK;
            end
            else
              next_state = CFGR_ST_IDLE;
          end
          else if (state == CFGR_ST_PTR)
          begin
            next_ptr   = shiftReg;
            next_sdaOe = 1'b1;
            next_state = CFGR_ST_PTR_ACK;
          end
          else
          begin
            next_reqTgl   = ~lnk.reqTgl;
            next_reqWrite = 1'b1;
            next_reqAddr  = ptr;
            next_reqData  = shiftReg;
            next_state    = CFGR_ST_WAIT_W;
          end
        end
      CFGR_ST_ADDR_ACK, CFGR_ST_MACK_OK:
        if (sclFall)
        begin
          next_sdaOe = 1'b0;
          if (isRead)
          begin
            next_reqTgl   = ~lnk.reqTgl;
            next_reqWrite = 1'b0;
            next_reqAddr  = ptr;
            next_state    = CFGR_ST_WAIT_R;
          end
          else
            next_state = CFGR_ST_PTR;
        end
      CFGR_ST_PTR_ACK, CFGR_ST_DATA_ACK:
        if (sclFall)
        begin
          next_sdaOe = 1'b0;
          next_state = CFGR_ST_WDATA;
        end
      CFGR_ST_WAIT_W:
        if (!busy)
        begin
          next_sdaOe = 1'b1;
          next_ptr   = ptr + 8'h01;
          next_state = CFGR_ST_DATA_ACK;
        end
      CFGR_ST_WAIT_R:
        if (!busy)
        begin
          next_shiftReg = lnk.rspData;
          next_sdaOe    = ~lnk.rspData[7];
          next_ptr      = ptr + 8'h01;
          next_bitCnt   = 4'h0;
          next_state    = CFGR_ST_TX;
        end
      CFGR_ST_TX:
        if (sclRise)
          next_bitCnt = bitCnt + 4'h1;
        else if (sclFall)
        begin
          if (bitCnt == 4'h8)
          begin
            next_sdaOe = 1'b0;
            next_state = CFGR_ST_MACK;
          end
          else
          begin
            next_shiftReg = {shiftReg[6:0], 1'b0};
            next_sdaOe    = ~shiftReg[6];
          end
        end
      CFGR_ST_MACK:
        if (sclRise)
          next_state = sdaS2 ? CFGR_ST_IDLE : CFGR_ST_MACK_OK;
      default: ;
    endcase
    if (startCond)
    begin
      next_state  = CFGR_ST_ADDR;
      next_bitCnt = 4'h0;
      next_sdaOe  = 1'b0;
    end
    else if (stopCond)
    begin
      next_state = CFGR_ST_IDLE;
      next_sdaOe = 1'b0;
    end
    next_sclOe = next_state == CFGR_ST_WAIT_W || next_state == CFGR_ST_WAIT_R;
  end

  always_ff @(posedge clkLink or posedge rst)
  begin
    if (rst)
    begin
      state        <= CFGR_ST_IDLE;
      shiftReg     <= 8'h00;
      bitCnt       <= 4'h0;
      ptr          <= 8'h00;
      isRead       <= 1'b0;
      sdaOe        <= 1'b0;
      sclOe        <= 1'b0;
      sdaOut       <= 1'b0;
      sclOut       <= 1'b0;
      lnk.reqTgl   <= 1'b0;
      lnk.reqWrite <= 1'b0;
      lnk.reqAddr  <= 8'h00;
      lnk.reqData  <= 8'h00;
    end
    else
    begin
      state        <= next_state;
      shiftReg     <= next_shiftReg;
      bitCnt       <= next_bitCnt;
      ptr          <= next_ptr;
      isRead       <= next_isRead;
      sdaOe        <= next_sdaOe;
      sclOe        <= next_sclOe;
      sdaOut       <= 1'b0;
      sclOut       <= 1'b0;
      lnk.reqTgl   <= next_reqTgl;
      lnk.reqWrite <= next_reqWrite;
      lnk.reqAddr  <= next_reqAddr;
      lnk.reqData  <= next_reqData;
    end
  end
endmodule
`default_nettype wire

/* File: cfgr_core.sv */
// Control register bank with strap-loaded bus address and soft resets
`timescale 1ns/1ns
`default_nettype none
`include "cfgr_cfg.svh"
module cfgr_core
  import cfgr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       clkLink,
  input  wire logic       rst,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  input  wire logic [2:0] addressStrapPin,
  input  wire logic [3:0] latchLowIn,
  input  wire logic [3:0] latchHighIn,
  output var  logic       sclOut,
  output var  logic       sclOe,
  output var  logic       sdaOut,
  output var  logic       sdaOe,
  output var  logic [6:0] activeAddress,
  output var  logic       fullLogicReset,
  output var  logic       logicResetKeepRegs
);
  localparam logic [7:0] RST_CYCLES = 8'(`CFGR_RST_CYCLES);

  cfgr_link_if lnk ();

  cfgr_i2c_slave u_slave (
    .clkLink (clkLink),
    .rst     (rst),
    .sclIn   (sclIn),
    .sdaIn   (sdaIn),
    .sclOut  (sclOut),
    .sclOe   (sclOe),
    .sdaOut  (sdaOut),
    .sdaOe   (sdaOe),
    .lnk     (lnk.link)
  );

  // Strap index to bus address
  function automatic logic [6:0] strap_to_addr(input logic [2:0] idx);
    logic [6:0] a;
    a = `CFGR_STRAP_ADDR0;
    case (idx)
      3'h1: a = `CFGR_STRAP_ADDR1;
      3'h2: a = `CFGR_STRAP_ADDR2;
      3'h3: a = `CFGR_STRAP_ADDR3;
      3'h4: a = `CFGR_STRAP_ADDR4;
      3'h5: a = `CFGR_STRAP_ADDR5;
      3'h6: a = `CFGR_STRAP_ADDR6;
      3'h7: a = `CFGR_STRAP_ADDR7;
      default: a = `CFGR_STRAP_ADDR0;
    endcase
    return a;
  endfunction

  logic       reqS1, reqS2, reqSeen;
  logic [2:0] strapS1, strapS2;
  logic [2:0] strapIdx, next_strapIdx;
  logic [1:0] strapWait, next_strapWait;
  logic       strapDone, next_strapDone;
  cfgr_byte_t busAddr, next_busAddr;
  logic [7:0] fullCnt, next_fullCnt, keepCnt, next_keepCnt;
  logic [3:0] llBits, next_llBits, lhBits, next_lhBits;
  logic       next_ackTgl, next_addrTgl;
  cfgr_byte_t next_rspData;
  logic [6:0] next_activeAddress;
  logic       next_fullLogicReset, next_keepRegsReset;
  logic       newReq, fullStart;

  // Request and strap synchronisers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      {reqS1, reqS2, reqSeen} <= 3'h0;
      strapS1 <= 3'h0;
      strapS2 <= 3'h0;
    end
    else
    begin
      {reqS1, reqS2, reqSeen} <= {lnk.reqTgl, reqS1, reqS2};
      strapS1 <= addressStrapPin;
      strapS2 <= strapS1;
    end
  end

  assign newReq = reqS2 != reqSeen;

  always_comb
  begin
    next_strapIdx      = strapIdx;
    next_strapWait     = strapWait;
    next_strapDone     = strapDone;
    next_busAddr       = busAddr;
    next_fullCnt       = fullCnt;
    next_keepCnt       = keepCnt;
    next_ackTgl        = lnk.ackTgl;
    next_rspData       = lnk.rspData;
    fullStart          = 1'b0;
    // Latched fields keep the condition until read
    next_llBits        = llBits & latchLowIn;
    next_lhBits        = lhBits | latchHighIn;
    // Reset actions count down, then their bits read zero
    if (fullCnt != 8'h00)
      next_fullCnt = fullCnt - 8'h01;
    if (keepCnt != 8'h00)
      next_keepCnt = keepCnt - 8'h01;
    // Strap capture after the pins have settled
    if (!strapDone)
    begin
      if (strapWait == `CFGR_STRAP_SETTLE)
      begin
        next_strapIdx  = strapS2;
        next_strapDone = 1'b1;
        next_busAddr   = {strap_to_addr(strapS2), busAddr[0]};
      end
      else
        next_strapWait = strapWait + 2'h1;
    end
    if (newReq)
    begin
      next_ackTgl = ~lnk.ackTgl;
      if (!lnk.reqWrite)
      begin
        if (lnk.reqAddr == `CFGR_OFF_BUS_ADDR)
          next_rspData = busAddr;
        else if (lnk.reqAddr == `CFGR_OFF_SOFT_RST)
          next_rspData = {6'h00, fullCnt != 8'h00, keepCnt != 8'h00};
        else if (lnk.reqAddr == `CFGR_OFF_LATCH)
        begin
          next_rspData = {lhBits, llBits};
          // Reload from the live inputs so an event in this cycle survives
          next_llBits  = latchLowIn;
          next_lhBits  = latchHighIn;
        end
        else
          next_rspData = 8'h00;
      end
      else
      begin
        if (lnk.reqAddr == `CFGR_OFF_BUS_ADDR)
          next_busAddr = lnk.reqData;
        else if (lnk.reqAddr == `CFGR_OFF_SOFT_RST)
        begin
          if (lnk.reqData[`CFGR_BIT_FULL])
          begin
            next_fullCnt = RST_CYCLES;
            fullStart    = 1'b1;
          end
          if (lnk.reqData[`CFGR_BIT_KEEP_REGS])
            next_keepCnt = RST_CYCLES;
        end
      end
    end
    // Full reset restores registers, strap fields from the original strap
    if (fullStart)
    begin
      next_busAddr = {strap_to_addr(strapIdx), 1'b0};
      next_llBits  = `CFGR_LL_RST;
      next_lhBits  = `CFGR_LH_RST;
    end
    // Address source select
    if (busAddr[`CFGR_BIT_SRC_SEL])
      next_activeAddress = busAddr[7:1];
    else
      next_activeAddress = strap_to_addr(strapIdx);
    next_addrTgl = lnk.addrTgl ^ (next_activeAddress != activeAddress);
    next_fullLogicReset = next_fullCnt != 8'h00;
    next_keepRegsReset  = next_keepCnt != 8'h00;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      strapIdx           <= 3'h0;
      strapWait          <= 2'h0;
      strapDone          <= 1'b0;
      busAddr            <= `CFGR_BUS_ADDR_RST;
      fullCnt            <= 8'h00;
      keepCnt            <= 8'h00;
      llBits             <= `CFGR_LL_RST;
      lhBits             <= `CFGR_LH_RST;
      lnk.ackTgl         <= 1'b0;
      lnk.rspData        <= 8'h00;
      lnk.addrTgl        <= 1'b0;
      lnk.busAddr        <= 7'h00;
      activeAddress      <= 7'h00;
      fullLogicReset     <= 1'b0;
      logicResetKeepRegs <= 1'b0;
    end
    else
    begin
      strapIdx           <= next_strapIdx;
      strapWait          <= next_strapWait;
      strapDone          <= next_strapDone;
      busAddr            <= next_busAddr;
      fullCnt            <= next_fullCnt;
      keepCnt            <= next_keepCnt;
      llBits             <= next_llBits;
      lhBits             <= next_lhBits;
      lnk.ackTgl         <= next_ackTgl;
      lnk.rspData        <= next_rspData;
      lnk.addrTgl        <= next_addrTgl;
      lnk.busAddr        <= next_activeAddress;
      activeAddress      <= next_activeAddress;
      fullLogicReset     <= next_fullLogicReset;
      logicResetKeepRegs <= next_keepRegsReset;
    end
  end
endmodule
`default_nettype wire

/* File: cfgr_core_properties.sv */
// Concurrent checks on the config register core ports
`timescale 1ns/1ns
`default_nettype none
`include "cfgr_cfg.svh"
module cfgr_core_properties
(
  input wire logic       clk_sys,
  input wire logic       clkLink,
  input wire logic       rst,
  input wire logic       sclIn,
  input wire logic [2:0] addressStrapPin,
  input wire logic       sclOut,
  input wire logic       sclOe,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic [6:0] activeAddress,
  input wire logic       fullLogicReset,
  input wire logic       logicResetKeepRegs
);
  function automatic logic [6:0] strap_addr(input logic [2:0] i);
    case (i)
      3'h0: return `CFGR_STRAP_ADDR0;
      3'h1: return `CFGR_STRAP_ADDR1;
      3'h2: return `CFGR_STRAP_ADDR2;
      3'h3: return `CFGR_STRAP_ADDR3;
      3'h4: return `CFGR_STRAP_ADDR4;
      3'h5: return `CFGR_STRAP_ADDR5;
      3'h6: return `CFGR_STRAP_ADDR6;
      default: return `CFGR_STRAP_ADDR7;
    endcase
  endfunction

  property p_full_len;
    @(posedge clk_sys) disable iff (rst)
    $rose(fullLogicReset) |-> fullLogicReset[*8] ##1 fullLogicReset[*2] ##1 !fullLogicReset;
  endproperty
  a_full_len: assert property (p_full_len) else $error("full pulse length wrong");

  property p_keep_len;
    @(posedge clk_sys) disable iff (rst)
    $rose(logicResetKeepRegs) |->
      logicResetKeepRegs[*8] ##1 logicResetKeepRegs[*2] ##1 !logicResetKeepRegs;
  endproperty
  a_keep_len: assert property (p_keep_len) else $error("keep pulse length wrong");

  property p_full_strap;
    @(posedge clk_sys) disable iff (rst)
    $rose(fullLogicReset) |-> ##[1:14] activeAddress == strap_addr(addressStrapPin);
  endproperty
  a_full_strap: assert property (p_full_strap) else $error("strap address not restored");

  property p_keep_stable;
    @(posedge clk_sys) disable iff (rst)
    logicResetKeepRegs |-> $stable(activeAddress);
  endproperty
  a_keep_stable: assert property (p_keep_stable) else $error("address lost in keep");

  property p_rst_strap;
    @(posedge clk_sys) disable iff (rst)
    $fell(rst) |-> ##5 activeAddress == strap_addr(addressStrapPin);
  endproperty
  a_rst_strap: assert property (p_rst_strap) else $error("strap address not loaded");

  property p_drive_low;
    @(posedge clkLink) disable iff (rst)
    !sdaOut && !sclOut && !(sclOe && sdaOe);
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("bad pin drive");

  property p_sda_in_low;
    @(posedge clkLink) disable iff (rst)
    $changed(sdaOe) |-> !sclIn;
  endproperty
  a_sda_in_low: assert property (p_sda_in_low) else $error("data changed, clock high");

  property p_stretch_low;
    @(posedge clkLink) disable iff (rst)
    $rose(sclOe) |-> !sclIn;
  endproperty
  a_stretch_low: assert property (p_stretch_low) else $error("stretch with clock high");
endmodule

bind cfgr_core cfgr_core_properties i_props (
  .clk_sys(clk_sys),
  .clkLink(clkLink),
  .rst(rst),
  .sclIn(sclIn),
  .addressStrapPin(addressStrapPin),
  .sclOut(sclOut),
  .sclOe(sclOe),
  .sdaOut(sdaOut),
  .sdaOe(sdaOe),
  .activeAddress(activeAddress),
  .fullLogicReset(fullLogicReset),
  .logicResetKeepRegs(logicResetKeepRegs)
);
`default_nettype wire

/* File: cfgr_host_model.sv */
// Host controller model acting as serial bus master
`timescale 1ns/1ns
`default_nettype none
module cfgr_host_model
(
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output var  logic sclPull,
  output var  logic sdaPull
);
  logic [6:0] devAddr = 7'h2c;
  logic       ackAll  = 1'b0;
  int         stallCnt = 0;
  initial sclPull = 1'b0;
  initial sdaPull = 1'b0;

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One bit, waiting out clock stretch
  task automatic bitx(input logic b, output logic r);
    int n;
    sdaPull = ~b;
    wt(6);
    sclPull = 1'b0;
    n = 0;
    while (scl !== 1'b1 && n < 100)
    begin
      wt(1);
      n++;
    end
    if (n >= 100) stallCnt++;
    wt(12);
    r = sda;
    sclPull = 1'b1;
    wt(7);
  endtask

  task automatic start();
    sdaPull = 1'b0;
    wt(6);
    sclPull = 1'b0;
    wt(13);
    sdaPull = 1'b1;
    wt(13);
    sclPull = 1'b1;
    wt(7);
  endtask

  task automatic stop();
    sdaPull = 1'b1;
    wt(6);
    sclPull = 1'b0;
    wt(13);
    sdaPull = 1'b0;
    wt(13);
  endtask

  // Byte then ninth bit, released unless the master acks; ack high when pulled low
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack,
                      input logic nine = 1'b1);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(nine, r);
    ack = ~r;
  endtask

  // Only mapped offsets are ever written
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    logic [7:0] q;
    logic       a1, a2, a3;
    start();
    xfer({devAddr, 1'b0}, q, a1);
    xfer(off, q, a2);
    xfer(d, q, a3);
    stop();
    ackAll = a1 & a2 & a3;
  endtask

  task automatic rd(input logic [7:0] off, output logic [7:0] d);
    logic [7:0] q;
    logic       a1, a2, a3, a4;
    start();
    xfer({devAddr, 1'b0}, q, a1);
    xfer(off, q, a2);
    start();
    xfer({devAddr, 1'b1}, q, a3);
    xfer(8'hff, d, a4);
    stop();
    ackAll = a1 & a2 & a3;
  endtask

  // Two bytes from consecutive offsets, master acks the first
  task automatic rd2(input logic [7:0] off, output logic [7:0] d0, output logic [7:0] d1);
    logic [7:0] q;
    logic       a1, a2, a3, a4;
    start();
    xfer({devAddr, 1'b0}, q, a1);
    xfer(off, q, a2);
    start();
    xfer({devAddr, 1'b1}, q, a3);
    xfer(8'hff, d0, a4, 1'b0);
    xfer(8'hff, d1, a4);
    stop();
    ackAll = a1 & a2 & a3;
  endtask
endmodule
`default_nettype wire

/* File: tb_config_register_core.sv */
// Testbench of the config register core
`timescale 1ns/1ns
`default_nettype none
`include "cfgr_cfg.svh"
module tb_config_register_core;
  import cfgr_pkg::*;
  typedef struct packed {logic [2:0] idx; logic [6:0] addr;} cfgr_row_s;
  logic       clk_sys   = 1'b0;
  logic       clkLink   = 1'b0;
  logic       rst       = 1'b1;
  logic [2:0] strap     = 3'h0;
  logic [3:0] latchLow  = 4'hf;
  logic [3:0] latchHigh = 4'h0;
  logic       sclOut, sclOe, sdaOut, sdaOe, mScl, mSda, fullRst, keepRst;
  logic [6:0] actAddr;
  logic       sawFull   = 1'b0;
  logic       sawKeep   = 1'b0;
  cfgr_byte_t rdData, rdNext;
  int         errorCnt       = 0;
  int         samplesChecked = 0;
  wire        sclW      = ~(sclOe | mScl);
  wire        sdaW      = ~(sdaOe | mSda);
  cfgr_row_s  rows [3]  = '{'{3'h0, `CFGR_STRAP_ADDR0}, '{3'h5, `CFGR_STRAP_ADDR5},
                            '{3'h7, `CFGR_STRAP_ADDR7}};

  always #50 clk_sys = ~clk_sys;
  initial #7 forever #15 clkLink = ~clkLink;
  always @(posedge clk_sys) if (fullRst === 1'b1) sawFull <= 1'b1;
  always @(posedge clk_sys) if (keepRst === 1'b1) sawKeep <= 1'b1;

  cfgr_core i_dut (
    .clk_sys(clk_sys),
    .clkLink(clkLink),
    .rst(rst),
    .sclIn(sclW),
    .sdaIn(sdaW),
    .addressStrapPin(strap),
    .latchLowIn(latchLow),
    .latchHighIn(latchHigh),
    .sclOut(sclOut),
    .sclOe(sclOe),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .activeAddress(actAddr),
    .fullLogicReset(fullRst),
    .logicResetKeepRegs(keepRst)
  );

  cfgr_host_model i_host (
    .clk(clk_sys),
    .scl(sclW),
    .sda(sdaW),
    .sclPull(mScl),
    .sdaPull(mSda)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finalReport();
    $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (80000) @(posedge clk_sys);
    errorCnt++;
    $display("ERROR %0t watchdog expired", $time);
    finalReport();
  end

  initial
  begin
    for (int i = 0; i < 3; i++)
    begin
      rst = 1'b1;
      strap = rows[i].idx;
      repeat (20) @(negedge clk_sys);
      rst = 1'b0;
      repeat (25) @(negedge clk_sys);
      check({1'b0, actAddr}, {1'b0, rows[i].addr});
      i_host.devAddr = rows[i].addr;
      i_host.rd(8'h00, rdData);
      check(rdData, {rows[i].addr, 1'b0});
      check({7'h0, i_host.ackAll}, 8'h01);
      $display("test strap row %0d done", i);
    end
    i_host.rd(8'h01, rdData);
    check(rdData, 8'h00);
    i_host.rd(8'h05, rdData);
    check(rdData, 8'h00);
    i_host.rd2(8'h00, rdData, rdNext);
    check(rdData, {`CFGR_STRAP_ADDR7, 1'b0});
    check(rdNext, 8'h00);
    check({7'h0, i_host.ackAll}, 8'h01);
    $display("test plain reads done");
    i_host.wr(8'h00, 8'ha1);
    check({7'h0, i_host.ackAll}, 8'h01);
    check({1'b0, actAddr}, 8'h50);
    i_host.devAddr = `CFGR_STRAP_ADDR7;
    i_host.wr(8'h00, 8'h00);
    check({7'h0, i_host.ackAll}, 8'h00);
    check({1'b0, actAddr}, 8'h50);
    $display("test address override done");
    i_host.devAddr = 7'h50;
    i_host.wr(8'h01, 8'hfd);
    check({7'h0, sawKeep}, 8'h01);
    i_host.rd(8'h00, rdData);
    check(rdData, 8'ha1);
    i_host.rd(8'h01, rdData);
    check(rdData, 8'h00);
    $display("test keep-register reset done");
    i_host.wr(8'h01, 8'h02);
    check({7'h0, sawFull}, 8'h01);
    check({1'b0, actAddr}, {1'b0, `CFGR_STRAP_ADDR7});
    i_host.devAddr = `CFGR_STRAP_ADDR7;
    i_host.rd(8'h00, rdData);
    check(rdData, {`CFGR_STRAP_ADDR7, 1'b0});
    $display("test full reset done");
    i_host.rd(8'h2c, rdData);
    check(rdData, 8'h0f);
    latchLow = 4'hd;
    latchHigh = 4'h4;
    @(negedge clk_sys);
    latchLow = 4'hf;
    latchHigh = 4'h0;
    i_host.rd(8'h2c, rdData);
    check(rdData, 8'h4d);
    i_host.rd(8'h2c, rdData);
    check(rdData, 8'h0f);
    check(8'(i_host.stallCnt), 8'h00);
    $display("test latched status done");
    finalReport();
  end
endmodule
`default_nettype wire
